/* File: verilog/rtv_top.sv */
// Lock indication, display qualification and accuracy flashing for a radio clock
`timescale 1ns/1ps
`include "rtv_consts.svh"
module rtv_top
    import rtv_pkg::*;
#(
    parameter int CLK_HZ        = `RTV_CLOCK_HZ,       // Cycles in one second
    parameter int LOCK_HOLD_SEC = `RTV_LOCK_HOLD_SEC,  // Lamp hold after lock loss
    parameter int COLON_SEC     = `RTV_COLON_LOSS_SEC, // Unlock seconds to flash colons
    parameter int DISPLAY_SEC   = `RTV_DISP_LOSS_SEC   // Unlock seconds to flash display
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset,
    // Receiver status and decoded frames
    input  wire logic                 carrier_locked,
    input  wire logic                 frame_strobe,
    input  wire rtv_pkg::rtv_frame_s  frame_time,
    // Rear selector
    input  wire logic [3:0]           offset_hours,
    // Front panel
    output logic                      carrier_lock_indicator,
    output logic                      display_on,
    output logic                      colons_on,
    // Corrected time for display and electrical outputs
    output rtv_pkg::rtv_time_s        shown_time,
    output logic                      time_valid,
    output logic                      colon_flash,
    output logic                      display_flash,
    output logic                      second_pulse
);
    import rtv_pkg::*;

    localparam int PW = $clog2(CLK_HZ);        // Prescaler width
    localparam int AW = $clog2(DISPLAY_SEC + 1); // Unlock accumulator width

    // ****************************************
    // Declarations
    // ****************************************
    logic [PW-1:0] prescale;        // Cycles within the current second
    logic          sec_tick;        // One cycle at each second boundary
    logic          blink_phase;     // High in the first half of each second
    logic [4:0]    lock_gap;        // Seconds of continuous lock loss, saturating
    logic [AW-1:0] unlock_total;    // Cumulative unlocked seconds since sync
    rtv_state_e    state;           // Display qualification state
    rtv_frame_s    last_frame;      // Previous decoded frame
    rtv_time_s     utc_time;        // Running universal time
    logic          frame_take;      // Frame arrives while locked
    logic          frame_agrees;    // Frame follows the previous one by a minute
    logic          sync_event;      // Lock plus a successfully read code

    // ****************************************
    // One second time base
    // ****************************************
    // The local oscillator keeps time even when lock is lost
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            prescale <= '0;
        end else if (prescale == PW'(CLK_HZ - 1)) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + PW'(1);
        end
    end

    assign sec_tick    = (prescale == PW'(CLK_HZ - 1));
    assign blink_phase = (prescale < PW'(CLK_HZ / 2));

    // Second pulse for outside logic, registered
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            second_pulse <= 1'b0;
        end else begin
            second_pulse <= sec_tick;
        end
    end

    // ****************************************
    // Lock indicator
    // ****************************************
    // Count whole seconds of continuous loss; saturate to avoid wrapping back on
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lock_gap <= 5'h1f;
        end else if (carrier_locked) begin
            lock_gap <= 5'h00;
        end else if (sec_tick && lock_gap != 5'h1f) begin
            lock_gap <= lock_gap + 5'h01;
        end
    end

    // Lamp lit on lock, held through short dropouts
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            carrier_lock_indicator <= 1'b0;
        end else if (carrier_locked) begin
            carrier_lock_indicator <= 1'b1;
        end else if (lock_gap > 5'(LOCK_HOLD_SEC)) begin
            carrier_lock_indicator <= 1'b0;
        end
    end

    // ****************************************
    // Frame qualification
    // ****************************************
    // Frames decoded without lock are not trusted
    assign frame_take   = frame_strobe && carrier_locked;
    assign frame_agrees = (frame_time == rtv_next_minute(last_frame));
    assign sync_event   = frame_take && (state != RTV_BLANK) && frame_agrees;

    // Keep the previous frame for the consecutive-agreement check
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            last_frame <= '0;
        end else if (frame_take) begin
            last_frame <= frame_time;
        end
    end

    // Blank until two agreeing frames; once lit, stay lit
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= RTV_BLANK;
        end else begin
            case (state)
                RTV_BLANK: begin
                    if (frame_take) begin
                        state <= RTV_ONE_FRAME;
                    end
                end
                RTV_ONE_FRAME: begin
                    if (sync_event) begin
                        state <= RTV_LIT;
                    end
                end
                RTV_LIT: begin
                    state <= RTV_LIT;
                end
                default: begin
                    state <= RTV_BLANK;
                end
            endcase
        end
    end

    // ****************************************
    // Running universal time
    // ****************************************
    // A synchronising frame loads its minute; the code content ends at second 35
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            utc_time <= '0;
        end else if (sync_event) begin
            utc_time.hm     <= frame_time;
            utc_time.second <= 6'(`RTV_FRAME_DATA_SEC);
        end else if (sec_tick) begin
            if (utc_time.second == 6'(`RTV_SEC_PER_MIN - 1)) begin
                utc_time.second <= 6'h00;
                utc_time.hm     <= rtv_next_minute(utc_time.hm);
            end else begin
                utc_time.second <= utc_time.second + 6'h01;
            end
        end
    end

    // ****************************************
    // Accumulated loss of lock
    // ****************************************
    // Sync wins over accumulation; the total saturates at the display limit
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            unlock_total <= '0;
        end else if (sync_event) begin
            unlock_total <= '0;
        end else if (sec_tick && !carrier_locked && unlock_total != AW'(DISPLAY_SEC)) begin
            unlock_total <= unlock_total + AW'(1);
        end
    end

    // Accuracy flags derived from the accumulator
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            colon_flash   <= 1'b0;
            display_flash <= 1'b0;
        end else begin
            colon_flash   <= (unlock_total >= AW'(COLON_SEC));
            display_flash <= (unlock_total >= AW'(DISPLAY_SEC));
        end
    end

    // ****************************************
    // Front panel drive
    // ****************************************
    // Whole-display flash overrides colon flash
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            display_on <= 1'b0;
            colons_on  <= 1'b0;
            time_valid <= 1'b0;
        end else if (state != RTV_LIT) begin
            display_on <= 1'b0;
            colons_on  <= 1'b0;
            time_valid <= 1'b0;
        end else begin
            time_valid <= 1'b1;
            display_on <= !display_flash || blink_phase;
            colons_on  <= !(display_flash || colon_flash) || blink_phase;
        end
    end

    // ****************************************
    // Hour correction
    // ****************************************
    rtv_hour_offset u_offset (
        .clock        (clock),
        .reset        (reset),
        .utc_time     (utc_time),
        .offset_hours (offset_hours),
        .local_time   (shown_time)
    );
endmodule

/* File: shared/rtv_consts.svh */
// Constants for the radio time validity and display block
`ifndef RTV_CONSTS_SVH
`define RTV_CONSTS_SVH

// ****************************************
// Clock and time figures
// ****************************************
`define RTV_CLOCK_HZ        100000000
`define RTV_LOCK_HOLD_SEC   16
`define RTV_COLON_LOSS_MIN  92
`define RTV_DISP_LOSS_HOUR  22
`define RTV_SEC_PER_MIN     60
`define RTV_MIN_PER_HOUR    60
`define RTV_HOUR_PER_DAY    24
`define RTV_FRAME_DATA_SEC  35
`define RTV_DAYS_PER_YEAR   365
`define RTV_MAX_OFFSET      11

// ****************************************
// Derived counts in seconds
// ****************************************
`define RTV_COLON_LOSS_SEC  (`RTV_COLON_LOSS_MIN * `RTV_SEC_PER_MIN)
`define RTV_DISP_LOSS_SEC   (`RTV_DISP_LOSS_HOUR * `RTV_MIN_PER_HOUR * `RTV_SEC_PER_MIN)

`endif

/* File: shared/rtv_pkg.sv */
// Types and time arithmetic shared by the time validity block
package rtv_pkg;
    `include "rtv_consts.svh"

    // ****************************************
    // Time of year carriers
    // ****************************************
    typedef struct packed {
        logic [8:0] day;     // Day of year, 1 based
        logic [4:0] hour;    // 0 to 23
        logic [5:0] minute;  // 0 to 59
    } rtv_frame_s;

    typedef struct packed {
        rtv_frame_s hm;      // Day, hour and minute
        logic [5:0] second;  // 0 to 59
    } rtv_time_s;

    // Display qualification states
    typedef enum logic [1:0] {
        RTV_BLANK     = 2'b00,
        RTV_ONE_FRAME = 2'b01,
        RTV_LIT       = 2'b10
    } rtv_state_e;

    // Advance a frame by one minute, wrapping hour, day and year
    function automatic rtv_frame_s rtv_next_minute(input rtv_frame_s t);
        rtv_frame_s n;
        n = t;
        if (t.minute == 6'(`RTV_MIN_PER_HOUR - 1)) begin
            n.minute = 6'h00;
            if (t.hour == 5'(`RTV_HOUR_PER_DAY - 1)) begin
                n.hour = 5'h00;
                n.day  = (t.day == 9'(`RTV_DAYS_PER_YEAR)) ? 9'h001 : t.day + 9'h001;
            end else begin
                n.hour = t.hour + 5'h01;
            end
        end else begin
            n.minute = t.minute + 6'h01;
        end
        return n;
    endfunction
endpackage

/* File: verilog/rtv_hour_offset.sv */
// Hour correction subtractor feeding display and electrical time outputs
`timescale 1ns/1ps
`include "rtv_consts.svh"
module rtv_hour_offset
    import rtv_pkg::*;
(
    // Clock and reset
    input  wire logic            clock,
    input  wire logic            reset,
    // Universal time in
    input  wire rtv_pkg::rtv_time_s utc_time,
    input  wire logic [3:0]      offset_hours,
    // Corrected time out
    output rtv_pkg::rtv_time_s   local_time
);
    import rtv_pkg::*;

    logic [3:0] offset_eff;  // Selector value clamped to the legal range
    logic [5:0] hour_diff;   // Hour less offset, borrow in bit 5
    rtv_time_s  next_local;  // Corrected time before the register

    // Out of range selector positions saturate at the largest offset
    assign offset_eff = (offset_hours > 4'(`RTV_MAX_OFFSET)) ? 4'(`RTV_MAX_OFFSET) : offset_hours;

    // ****************************************
    // Subtraction with midnight wrap
    // ****************************************
    always_comb begin
        next_local = utc_time;
        hour_diff  = {1'b0, utc_time.hm.hour} - {2'b00, offset_eff};
        if (hour_diff[5]) begin
            // Borrow: wrap the hour and step back one day
            next_local.hm.hour = 5'(hour_diff + 6'(`RTV_HOUR_PER_DAY));
            next_local.hm.day  = (utc_time.hm.day <= 9'h001) ? 9'(`RTV_DAYS_PER_YEAR)
                                                            : utc_time.hm.day - 9'h001;
        end else begin
            next_local.hm.hour = hour_diff[4:0];
        end
    end

    // One register serves every consumer, so all outputs agree
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            local_time <= '0;
        end else begin
            local_time <= next_local;
        end
    end
endmodule

/* File: dv/rtv_checker.sv */
// Assertion checker bound to the radio time validity top
`timescale 1ns/1ps
module rtv_checker
    import rtv_pkg::*;
#(
    parameter int CLK_HZ        = 10, // Cycles in one second
    parameter int LOCK_HOLD_SEC = 16  // Lamp hold after lock loss
) (
    // Clock and reset
    input wire logic                clock,
    input wire logic                reset,
    // Receiver and selector
    input wire logic                carrier_locked,
    input wire logic                frame_strobe,
    input wire rtv_pkg::rtv_frame_s frame_time,
    input wire logic [3:0]          offset_hours,
    // Panel and time outputs
    input wire logic                carrier_lock_indicator,
    input wire logic                display_on,
    input wire logic                colons_on,
    input wire rtv_pkg::rtv_time_s  shown_time,
    input wire logic                time_valid,
    input wire logic                colon_flash,
    input wire logic                display_flash,
    input wire logic                second_pulse
);
    localparam int HOLD = LOCK_HOLD_SEC * CLK_HZ; // Hold in cycles
    logic [15:0] gap;                             // Cycles since lock seen
    // Starts saturated: the lamp must stay dark until the first lock
    always_ff @(posedge clock or posedge reset) begin
        if (reset) gap <= 16'hffff;
        else if (carrier_locked) gap <= 16'h0000;
        else if (gap != 16'hffff) gap <= gap + 16'h0001;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Margins allow for the free running second tick
    property p_lamp_on; carrier_locked |=> carrier_lock_indicator; endproperty
    a_lamp_on: assert property (p_lamp_on) else $error("lamp dark after lock");
    property p_lamp_hold; (gap != 16'h0000 && gap < 16'(HOLD)) |-> carrier_lock_indicator; endproperty
    a_lamp_hold: assert property (p_lamp_hold) else $error("lamp dropped early");
    property p_lamp_off; (gap > 16'(HOLD + 2 * CLK_HZ)) |-> !carrier_lock_indicator; endproperty
    a_lamp_off: assert property (p_lamp_off) else $error("lamp still lit");
    property p_blank; !time_valid |-> !display_on; endproperty
    a_blank: assert property (p_blank) else $error("digits lit unqualified");
    property p_sticky; time_valid |=> time_valid; endproperty
    a_sticky: assert property (p_sticky) else $error("qualification lost");
    property p_lit; (time_valid && !display_flash && !$past(display_flash)) |-> display_on; endproperty
    a_lit: assert property (p_lit) else $error("digits dark while valid");
    property p_colons;
        (time_valid && !colon_flash && !display_flash && !$past(colon_flash) && !$past(display_flash))
            |-> colons_on;
    endproperty
    a_colons: assert property (p_colons) else $error("colons dark without flash");
    property p_order; display_flash |-> colon_flash; endproperty
    a_order: assert property (p_order) else $error("display flash without colon flash");
    c_lamp: cover property ($fell(carrier_lock_indicator));
    c_valid: cover property ($rose(time_valid));
    c_disp: cover property ($rose(display_flash));
endmodule

bind rtv_top rtv_checker #(.CLK_HZ(CLK_HZ), .LOCK_HOLD_SEC(LOCK_HOLD_SEC)) u_checker (
    .clock(clock), .reset(reset), .carrier_locked(carrier_locked), .frame_strobe(frame_strobe),
    .frame_time(frame_time), .offset_hours(offset_hours), .carrier_lock_indicator(carrier_lock_indicator),
    .display_on(display_on), .colons_on(colons_on), .shown_time(shown_time), .time_valid(time_valid),
    .colon_flash(colon_flash), .display_flash(display_flash), .second_pulse(second_pulse));

/* File: dv/rtv_rx_model.sv */
// Receiver model: phase lock status and decoded minute frames
`timescale 1ns/1ps
module rtv_rx_model
    import rtv_pkg::*;
(
    // Clock in, receiver status and frames out
    input  wire logic           clock,
    output logic                carrier_locked,
    output logic                frame_strobe,
    output rtv_pkg::rtv_frame_s frame_time
);
    initial begin
        carrier_locked = 1'b0;
        frame_strobe = 1'b0;
        frame_time = '0;
    end
    // Lock level moves just after an edge
    task automatic set_lock(input logic on);
        @(posedge clock);
        #1 carrier_locked = on;
    endtask
    // One cycle strobe; data is not held after it, so it shows the inverse
    task automatic send(input rtv_frame_s f);
        @(posedge clock);
        #1 frame_strobe = 1'b1;
        frame_time = f;
        @(posedge clock);
        #1 frame_strobe = 1'b0;
        frame_time = ~f;
    endtask
endmodule

/* File: dv/tb_top.sv */
// Self-checking testbench for the radio time validity block
`timescale 1ns/1ps
module tb_top;
    import rtv_pkg::*;
    logic       clock, reset, carrier_locked, frame_strobe, lamp, sec_pulse;
    logic       display_on, colons_on, time_valid, colon_flash, display_flash;
    logic [3:0] offset_hours;
    rtv_frame_s frame_time, f;
    rtv_time_s  shown_time;
    int         n_mismatch = 0, tests_run = 0, cycles = 0, cl, dl, sp;
    rtv_rx_model rx (.clock(clock), .carrier_locked(carrier_locked), .frame_strobe(frame_strobe),
        .frame_time(frame_time));
    // Ten cycle second keeps the unlock counts short
    rtv_top #(.CLK_HZ(10), .COLON_SEC(4), .DISPLAY_SEC(8)) uut (
        .clock(clock), .reset(reset), .carrier_locked(carrier_locked), .frame_strobe(frame_strobe),
        .frame_time(frame_time), .offset_hours(offset_hours), .carrier_lock_indicator(lamp),
        .display_on(display_on), .colons_on(colons_on), .shown_time(shown_time),
        .time_valid(time_valid), .colon_flash(colon_flash), .display_flash(display_flash),
        .second_pulse(sec_pulse));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_time(input rtv_time_s got, input rtv_time_s exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Wait for edges, then let their updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    // Dark cycles of colons and digits, and second pulses, over one second
    task automatic blink();
        cl = 0;
        dl = 0;
        sp = 0;
        repeat (10) begin
            cyc(1);
            cl += (colons_on === 1'b0);
            dl += (display_on === 1'b0);
            sp += (sec_pulse === 1'b1);
        end
    endtask
    // Reference frame, then the agreeing next minute; f ends as the taken time
    task automatic sync();
        rx.send(f);
        f.minute = f.minute + 6'h01;
        rx.send(f);
        #1;
    endtask
    task automatic t_lock();
        chk_bit(lamp, 1'b0);
        chk_bit(display_on, 1'b0);
        rx.set_lock(1'b1);
        cyc(2);
        chk_bit(lamp, 1'b1);
        rx.set_lock(1'b0);
        cyc(100);
        chk_bit(lamp, 1'b1);
        rx.set_lock(1'b1);
        rx.set_lock(1'b0);
        cyc(200);
        chk_bit(lamp, 1'b0);
    endtask
    // Unlocked frame is ignored, a disagreeing one only re-arms
    task automatic t_qualify();
        f = '{day: 9'h00a, hour: 5'h03, minute: 6'h0a};
        rx.send(f);
        rx.set_lock(1'b1);
        f.minute = 6'h0b;
        rx.send(f);
        #1 chk_bit(time_valid, 1'b0);
        f.minute = 6'h0d;
        sync();
        cyc(1);
        chk_bit(time_valid, 1'b1);
        chk_time(shown_time, '{hm: f, second: 6'h23});
        cyc(2);
        chk_bit(display_on, 1'b1);
    endtask
    // Offsets across midnight of day one, with a clamped selector value
    task automatic t_offset();
        logic [3:0] offs [5] = '{4'h0, 4'h3, 4'h5, 4'hb, 4'hf};
        logic [8:0] days [5] = '{9'h001, 9'h001, 9'h16d, 9'h16d, 9'h16d};
        logic [4:0] hrs [5] = '{5'h03, 5'h00, 5'h16, 5'h10, 5'h10};
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            #1 offset_hours = offs[i];
            f = '{day: 9'h001, hour: 5'h03, minute: 6'h0a};
            sync();
            cyc(1);
            chk_time(shown_time, '{hm: '{day: days[i], hour: hrs[i], minute: 6'h0b}, second: 6'h23});
        end
    endtask
    task automatic t_flash();
        f = '{day: 9'h064, hour: 5'h0c, minute: 6'h1e};
        sync();
        rx.set_lock(1'b0);
        cyc(25);
        chk_bit(colon_flash, 1'b0);
        cyc(30);
        chk_bit(colon_flash, 1'b1);
        blink();
        chk_bit(cl != 0, 1'b1);
        chk_bit(dl == 0, 1'b1);
        chk_bit(sp == 1, 1'b1);
        cyc(35);
        chk_bit(display_flash, 1'b1);
        blink();
        chk_bit(dl != 0, 1'b1);
        rx.set_lock(1'b1);
        cyc(20);
        chk_bit(colon_flash, 1'b1);
        sync();
        cyc(2);
        chk_bit(colon_flash, 1'b0);
        chk_bit(display_flash, 1'b0);
    endtask
    initial begin
        reset = 1'b1;
        offset_hours = 4'h0;
        repeat (4) @(posedge clock);
        #1 reset = 1'b0;
        t_lock();
        t_qualify();
        t_offset();
        t_flash();
        finish_test();
    end
endmodule
